// >>> usb_ep_pkg.sv
// Shared constants and types for the low-speed endpoint control block
package usb_ep_pkg;
  // Register addresses
  localparam logic [7:0] EP0_TX_CTRL_ADDR = 8'hEA;
  localparam logic [7:0] EP12_TX_CTRL_ADDR = 8'hEB;
  localparam logic [7:0] EP_ENABLE_CTRL_ADDR = 8'hEC;
  // Reset values
  localparam logic [7:0] EP0_TX_CTRL_RST = 8'h00;
  localparam logic [7:0] EP12_TX_CTRL_RST = 8'h00;
  localparam logic [7:0] EP_ENABLE_CTRL_RST = 8'h00;
  // Field positions, endpoint 0 transmit control
  localparam int EP0_TOGGLE_BIT = 7;
  localparam int EP0_STALL_BIT = 6;
  localparam int EP0_TXE_BIT = 5;
  localparam int EP0_RXE_BIT = 4;
  // Field positions, endpoint 1/2 transmit control
  localparam int EP12_TOGGLE_BIT = 7;
  localparam int EP12_TARGET_BIT = 6;
  localparam int EP12_TXE_BIT = 5;
  localparam int WAKEUP_BIT = 4;
  // Count field, bits 3 to 0
  localparam int COUNT_MSB = 3;
  localparam int COUNT_LSB = 0;
  // Field positions, endpoint enable control
  localparam int AUTO_STATUS_BIT = 4;
  localparam int EP2_EN_BIT = 3;
  localparam int EP1_EN_BIT = 2;
  localparam int EP2_STALL_BIT = 1;
  localparam int EP1_STALL_BIT = 0;
  localparam logic [7:0] EP_ENABLE_WMASK = 8'h1F;
  // Endpoint numbers
  localparam logic [3:0] EP_ZERO = 4'h0;
  localparam logic [3:0] EP_ONE = 4'h1;
  localparam logic [3:0] EP_TWO = 4'h2;

  // Token kinds from the packet engine
  typedef enum logic [1:0] {
    TOK_IN = 2'h0,
    TOK_OUT = 2'h1,
    TOK_SETUP = 2'h2
  } tok_kind_t;

  // Answer kinds toward the packet engine
  typedef enum logic [2:0] {
    ANS_NONE = 3'h0,
    ANS_DATA = 3'h1,
    ANS_ACK = 3'h2,
    ANS_NAK = 3'h3,
    ANS_STALL = 3'h4
  } ans_kind_t;

  typedef struct packed {
    logic valid;
    tok_kind_t kind;
    logic [3:0] ep;
  } token_t;

  typedef struct packed {
    logic valid;
    ans_kind_t kind;
    logic data1;
    logic [3:0] count;
    logic [3:0] ep;
  } answer_t;
endpackage

// >>> usb_lowspeed_endpoint_control.sv
// Endpoint answer decision, control registers and forced wake-up drive
`timescale 1ns/10ps
module usb_lowspeed_endpoint_control
  import usb_ep_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Token from packet engine and answer back
  input wire token_t token,
  output answer_t answer,
  // Handshake events from packet engine
  input wire logic ep0_in_acked,
  input wire logic ep12_in_acked,
  input wire logic ep0_out_taken,
  // Flag clears from firmware
  input wire logic ep0_tx_done_clr,
  input wire logic ep0_rx_done_clr,
  input wire logic ep12_tx_done_clr,
  input wire logic wakeup_seen_clr,
  // Bus state
  input wire logic suspended,
  input wire logic bus_activity_pin,
  output logic bus_dp_o,
  output logic bus_dm_o,
  output logic bus_oe,
  // Flags and shared buffer target
  output logic ep0_tx_done_flag,
  output logic ep0_rx_done_flag,
  output logic ep12_tx_done_flag,
  output logic wakeup_seen_flag,
  output logic shared_buf_target
);

  logic [7:0] ep0_ctrl_ff;
  logic [7:0] ep12_ctrl_ff;
  logic [7:0] ep_en_ctrl_ff;
  logic ep0_txd_ff;
  logic ep0_rxd_ff;
  logic ep12_txd_ff;
  logic wake_seen_ff;
  logic act_sync1_ff;
  logic act_sync2_ff;
  logic k_drive_ff;
  logic [1:0] k_trail_ff;
  answer_t answer_ff;
  answer_t nxt_answer;
  logic setup_ep0;

  // Named fields
  logic ep0_toggle_sel;
  logic ep0_force_stall;
  logic ep0_tx_enable;
  logic ep0_rx_enable;
  logic [3:0] ep0_tx_count;
  logic ep12_toggle_sel;
  logic ep12_tx_enable;
  logic force_wakeup;
  logic [3:0] ep12_tx_count;
  logic auto_status_out;
  logic ep_two_enable;
  logic ep_one_enable;
  logic ep_two_force_stall;
  logic ep_one_force_stall;

  assign ep0_toggle_sel = ep0_ctrl_ff[EP0_TOGGLE_BIT];
  assign ep0_force_stall = ep0_ctrl_ff[EP0_STALL_BIT];
  assign ep0_tx_enable = ep0_ctrl_ff[EP0_TXE_BIT];
  assign ep0_rx_enable = ep0_ctrl_ff[EP0_RXE_BIT];
  assign ep0_tx_count = ep0_ctrl_ff[COUNT_MSB:COUNT_LSB];
  assign ep12_toggle_sel = ep12_ctrl_ff[EP12_TOGGLE_BIT];
  assign shared_buf_target = ep12_ctrl_ff[EP12_TARGET_BIT];
  assign ep12_tx_enable = ep12_ctrl_ff[EP12_TXE_BIT];
  assign force_wakeup = ep12_ctrl_ff[WAKEUP_BIT];
  assign ep12_tx_count = ep12_ctrl_ff[COUNT_MSB:COUNT_LSB];
  assign auto_status_out = ep_en_ctrl_ff[AUTO_STATUS_BIT];
  assign ep_two_enable = ep_en_ctrl_ff[EP2_EN_BIT];
  assign ep_one_enable = ep_en_ctrl_ff[EP1_EN_BIT];
  assign ep_two_force_stall = ep_en_ctrl_ff[EP2_STALL_BIT];
  assign ep_one_force_stall = ep_en_ctrl_ff[EP1_STALL_BIT];

  assign setup_ep0 = token.valid && (token.kind == TOK_SETUP) && (token.ep == EP_ZERO);

  // Endpoint 0 control register; SETUP clear beats a same-cycle write
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ep0_ctrl_ff <= EP0_TX_CTRL_RST;
    else if (clk_en)
    begin
      if (sfr_wr && sfr_addr == EP0_TX_CTRL_ADDR)
        ep0_ctrl_ff <= sfr_wdata;
      if (setup_ep0)
        ep0_ctrl_ff[EP0_STALL_BIT] <= 1'b0;
    end
  end

  // Endpoint 1/2 control register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ep12_ctrl_ff <= EP12_TX_CTRL_RST;
    else if (clk_en && sfr_wr && sfr_addr == EP12_TX_CTRL_ADDR)
      ep12_ctrl_ff <= sfr_wdata;
  end

  // Endpoint enable register; reserved bits stay zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ep_en_ctrl_ff <= EP_ENABLE_CTRL_RST;
    else if (clk_en && sfr_wr && sfr_addr == EP_ENABLE_CTRL_ADDR)
      ep_en_ctrl_ff <= sfr_wdata & EP_ENABLE_WMASK;
  end

  // Read mux
  always_comb
  begin
    case (sfr_addr)
      EP0_TX_CTRL_ADDR: sfr_rdata = ep0_ctrl_ff;
      EP12_TX_CTRL_ADDR: sfr_rdata = ep12_ctrl_ff;
      EP_ENABLE_CTRL_ADDR: sfr_rdata = ep_en_ctrl_ff;
      default: sfr_rdata = 8'h00;
    endcase
  end

  // Done flags; hardware set wins over firmware clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ep0_txd_ff <= 1'b0;
      ep0_rxd_ff <= 1'b0;
      ep12_txd_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      ep0_txd_ff <= ep0_in_acked | (ep0_txd_ff & ~ep0_tx_done_clr);
      ep0_rxd_ff <= ep0_out_taken | (ep0_rxd_ff & ~ep0_rx_done_clr);
      ep12_txd_ff <= ep12_in_acked | (ep12_txd_ff & ~ep12_tx_done_clr);
    end
  end

  // Bus activity synchroniser
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_sync1_ff <= 1'b0;
      act_sync2_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      act_sync1_ff <= bus_activity_pin;
      act_sync2_ff <= act_sync1_ff;
    end
  end

  // Wake-up seen flag, only from bus activity while suspended
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_seen_ff <= 1'b0;
    else if (clk_en)
      wake_seen_ff <= (act_sync2_ff & suspended & ~k_drive_ff & ~(|k_trail_ff))
        | (wake_seen_ff & ~wakeup_seen_clr);
  end

  // Own K echo lags two synchroniser stages; keep it masked that long
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      k_trail_ff <= 2'h0;
    else if (clk_en)
      k_trail_ff <= {k_trail_ff[0], k_drive_ff};
  end

  // Forced K state drive: D+ high, D- low at low speed
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      k_drive_ff <= 1'b0;
    else if (clk_en)
      k_drive_ff <= force_wakeup;
  end

  assign bus_oe = k_drive_ff;
  assign bus_dp_o = k_drive_ff;
  assign bus_dm_o = 1'b0;

  // Answer decision for the token in this cycle
  always_comb
  begin
    nxt_answer = '0;
    nxt_answer.valid = token.valid;
    nxt_answer.ep = token.ep;
    nxt_answer.kind = ANS_NONE;
    if (token.valid)
    begin
      if (token.kind == TOK_SETUP)
        nxt_answer.kind = (token.ep == EP_ZERO) ? ANS_ACK : ANS_NONE;
      else if (token.ep == EP_ZERO)
      begin
        if (ep0_force_stall)
          nxt_answer.kind = ANS_STALL;
        else if (token.kind == TOK_IN)
        begin
          if (!ep0_tx_enable || ep0_txd_ff)
            nxt_answer.kind = ANS_NAK;
          else
          begin
            nxt_answer.kind = ANS_DATA;
            nxt_answer.data1 = ep0_toggle_sel;
            nxt_answer.count = ep0_tx_count;
          end
        end
        else if (auto_status_out)
          nxt_answer.kind = ANS_ACK;
        else if (!ep0_rx_enable || ep0_rxd_ff)
          nxt_answer.kind = ANS_NAK;
        else
          nxt_answer.kind = ANS_ACK;
      end
      else if (token.ep == EP_ONE || token.ep == EP_TWO)
      begin
        if ((token.ep == EP_ONE && !ep_one_enable) || (token.ep == EP_TWO && !ep_two_enable))
          nxt_answer.kind = ANS_NONE;
        else if ((token.ep == EP_ONE && ep_one_force_stall)
                 || (token.ep == EP_TWO && ep_two_force_stall))
          nxt_answer.kind = ANS_STALL;
        else if (token.kind != TOK_IN)
          nxt_answer.kind = ANS_STALL;
        else if (!ep12_tx_enable || ep12_txd_ff)
          nxt_answer.kind = ANS_NAK;
        else if (shared_buf_target != (token.ep == EP_TWO))
          nxt_answer.kind = ANS_NAK;
        else
        begin
          nxt_answer.kind = ANS_DATA;
          nxt_answer.data1 = ep12_toggle_sel;
          nxt_answer.count = ep12_tx_count;
        end
      end
    end
  end

  // Registered answer, one cycle after the token
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      answer_ff <= '0;
    else if (clk_en)
      answer_ff <= nxt_answer;
  end

  assign answer = answer_ff;
  assign ep0_tx_done_flag = ep0_txd_ff;
  assign ep0_rx_done_flag = ep0_rxd_ff;
  assign ep12_tx_done_flag = ep12_txd_ff;
  assign wakeup_seen_flag = wake_seen_ff;
endmodule

// >>> usb_ep_chk.sv
// Checker of endpoint answers and forced wake-up drive
`timescale 1ns/10ps
module usb_ep_chk
  import usb_ep_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_rdata,
  input wire token_t token,
  input wire answer_t answer,
  input wire logic ep0_in_acked,
  input wire logic ep0_tx_done_flag,
  input wire logic bus_dp_o,
  input wire logic bus_dm_o,
  input wire logic bus_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Control register in view with no write landing
  wire logic s0 = sfr_addr == EP0_TX_CTRL_ADDR && !sfr_wr;
  wire logic s1 = sfr_addr == EP12_TX_CTRL_ADDR && !sfr_wr;
  // Token taken for one endpoint
  sequence tok(logic [3:0] e);
    clk_en && token.valid && token.ep == e;
  endsequence
  a_ep0_data_pid:
    assert property (tok(EP_ZERO) ##0 token.kind == TOK_IN && s0 && sfr_rdata[6:5] == 2'h1
      && !ep0_tx_done_flag |=> answer.kind == ANS_DATA && answer.data1 == $past(sfr_rdata[7])
      && answer.count == $past(sfr_rdata[3:0])) else $error("ep0 data bad");
  a_ep0_stall:
    assert property (tok(EP_ZERO) ##0 token.kind != TOK_SETUP && s0 && sfr_rdata[6]
      |=> answer.kind == ANS_STALL) else $error("ep0 no stall");
  a_setup_clr:
    assert property (tok(EP_ZERO) ##0 token.kind == TOK_SETUP ##1 s0 |-> !sfr_rdata[6])
      else $error("stall kept");
  a_ep0_in_nak:
    assert property (tok(EP_ZERO) ##0 token.kind == TOK_IN && s0 && !sfr_rdata[6]
      && (!sfr_rdata[5] || ep0_tx_done_flag) |=> answer.kind == ANS_NAK) else $error("ep0 no nak");
  a_done_set:
    assert property (clk_en && ep0_in_acked |=> ep0_tx_done_flag) else $error("flag not set");
  a_ep2_target:
    assert property (tok(EP_TWO) ##0 token.kind == TOK_IN && s1 && !sfr_rdata[6]
      |=> answer.kind != ANS_DATA) else $error("ep2 wrong data");
  a_ep12_nak:
    assert property (tok(EP_ONE) ##0 token.kind == TOK_IN && s1 && !sfr_rdata[5]
      |=> answer.kind != ANS_DATA) else $error("ep1 sent data");
  a_wake_k:
    assert property (clk_en && s1 && sfr_rdata[4] |=> bus_oe && bus_dp_o && !bus_dm_o)
      else $error("no K state");
endmodule
bind usb_lowspeed_endpoint_control usb_ep_chk chk (.ref_clk, .rst_n, .clk_en, .sfr_addr,
  .sfr_wr, .sfr_rdata, .token, .answer, .ep0_in_acked, .ep0_tx_done_flag, .bus_dp_o,
  .bus_dm_o, .bus_oe);

// >>> usb_host_model.sv
// Host model: tokens and handshake events toward the block
`timescale 1ns/10ps
module usb_host_model
  import usb_ep_pkg::*;
(
  input wire logic ref_clk,
  input wire answer_t answer,
  output token_t token,
  output logic [2:0] ev
);
  // Idle, nothing sent
  initial
  begin
    token = '0;
    ev = 3'h0;
  end
  // Token for one cycle, answer taken the cycle after; released fields flipped
  task automatic send(input tok_kind_t k, input logic [3:0] e, output answer_t r);
    @(posedge ref_clk);
    token <= '{1'h1, k, e};
    @(posedge ref_clk);
    token <= '{1'h0, tok_kind_t'(~k), ~e};
    #1 r = answer;
  endtask
  // One-cycle event: 0 ep0 ACK, 1 ep1/2 ACK, 2 ep0 OUT data
  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'h1;
    @(posedge ref_clk);
    ev[i] <= 1'h0;
  endtask
endmodule

// >>> usb_lowspeed_endpoint_control_tb.sv
// Self-checking bench for the endpoint control block
`timescale 1ns/10ps
module usb_lowspeed_endpoint_control_tb;
  import usb_ep_pkg::*;
  localparam logic [7:0] A0 = EP0_TX_CTRL_ADDR;
  localparam logic [7:0] A1 = EP12_TX_CTRL_ADDR;
  localparam logic [7:0] A2 = EP_ENABLE_CTRL_ADDR;
  logic ref_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, sfr_wr = 1'h0, susp = 1'h0, act = 1'h0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [3:0] clr = 4'h0;
  logic [2:0] ev;
  logic dp, dm, oe, f0t, f0r, f12t, fw, tgt;
  token_t token;
  answer_t answer, a;
  int errors = 0, n_compared = 0;
  // Clock, 8 ns period
  initial forever #4 ref_clk = ~ref_clk;
  usb_lowspeed_endpoint_control dut (.ref_clk, .rst_n, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rdata, .token, .answer, .ep0_in_acked(ev[0]), .ep12_in_acked(ev[1]),
    .ep0_out_taken(ev[2]), .ep0_tx_done_clr(clr[0]), .ep0_rx_done_clr(clr[1]),
    .ep12_tx_done_clr(clr[2]), .wakeup_seen_clr(clr[3]), .suspended(susp),
    .bus_activity_pin(act), .bus_dp_o(dp), .bus_dm_o(dm), .bus_oe(oe), .ep0_tx_done_flag(f0t),
    .ep0_rx_done_flag(f0r), .ep12_tx_done_flag(f12t), .wakeup_seen_flag(fw),
    .shared_buf_target(tgt));
  usb_host_model host (.ref_clk, .answer, .token, .ev);
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= ad;
    sfr_wr <= 1'h1;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= ad;
    #1 chk(12'(sfr_rdata), 12'(e));
  endtask
  // Flag clear pulse, settled value readable on return plus 1 ns
  task automatic cl(input int i);
    @(posedge ref_clk);
    clr[i] <= 1'h1;
    @(posedge ref_clk);
    clr[i] <= 1'h0;
  endtask
  // Token and answer; dc is {data1, count}, judged only for DATA
  task automatic tk(input tok_kind_t k, input logic [3:0] e, input ans_kind_t x,
    input logic [4:0] dc = 5'h00);
    host.send(k, e, a);
    chk(12'({a.valid, a.kind, x == ANS_DATA ? {a.data1, a.count} : 5'h00}), 12'({1'h1, x, dc}));
  endtask
  task automatic t_regs;
    rd(A0, EP0_TX_CTRL_RST);
    rd(A1, EP12_TX_CTRL_RST);
    rd(A2, EP_ENABLE_CTRL_RST);
    wr(A2, 8'hFF);
    rd(A2, 8'h1F);
    wr(8'hE9, 8'hFF);
    rd(8'hE9, 8'h00);
    wr(A2, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'h0;
    wr(A2, 8'h1F);
    rd(A2, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'h1;
    $display("regs done");
  endtask
  task automatic t_ep0;
    wr(A0, 8'h23);
    tk(TOK_IN, EP_ZERO, ANS_DATA, 5'h03);
    wr(A0, 8'hA8);
    tk(TOK_IN, EP_ZERO, ANS_DATA, 5'h18);
    host.pulse(0);
    #1 chk(12'(f0t), 12'h1);
    tk(TOK_IN, EP_ZERO, ANS_NAK);
    cl(0);
    #1 chk(12'(f0t), 12'h0);
    wr(A0, 8'h08);
    tk(TOK_IN, EP_ZERO, ANS_NAK);
    wr(A0, 8'h60);
    tk(TOK_IN, EP_ZERO, ANS_STALL);
    tk(TOK_OUT, EP_ZERO, ANS_STALL);
    tk(TOK_SETUP, EP_ZERO, ANS_ACK);
    rd(A0, 8'h20);
    tk(TOK_OUT, EP_ZERO, ANS_NAK);
    wr(A0, 8'h10);
    tk(TOK_OUT, EP_ZERO, ANS_ACK);
    host.pulse(2);
    #1 chk(12'(f0r), 12'h1);
    tk(TOK_OUT, EP_ZERO, ANS_NAK);
    wr(A2, 8'h10);
    tk(TOK_OUT, EP_ZERO, ANS_ACK);
    cl(1);
    #1 chk(12'(f0r), 12'h0);
    wr(A2, 8'h00);
    wr(A0, 8'h00);
    $display("ep0 done");
  endtask
  task automatic t_ep12;
    wr(A2, 8'h0C);
    wr(A1, 8'h25);
    tk(TOK_IN, EP_ONE, ANS_DATA, 5'h05);
    chk(12'(tgt), 12'h0);
    tk(TOK_IN, EP_TWO, ANS_NAK);
    wr(A1, 8'hE7);
    tk(TOK_IN, EP_TWO, ANS_DATA, 5'h17);
    chk(12'(tgt), 12'h1);
    wr(A1, 8'h47);
    tk(TOK_IN, EP_TWO, ANS_NAK);
    tk(TOK_IN, EP_ONE, ANS_NAK);
    wr(A1, 8'h67);
    host.pulse(1);
    #1 chk(12'(f12t), 12'h1);
    tk(TOK_IN, EP_TWO, ANS_NAK);
    cl(2);
    #1 chk(12'(f12t), 12'h0);
    tk(TOK_IN, EP_TWO, ANS_DATA, 5'h07);
    wr(A2, 8'h0E);
    tk(TOK_IN, EP_TWO, ANS_STALL);
    wr(A2, 8'h00);
    tk(TOK_IN, EP_ONE, ANS_NONE);
    wr(A1, 8'h00);
    $display("ep12 done");
  endtask
  task automatic t_wake;
    @(posedge ref_clk);
    susp <= 1'h1;
    wr(A1, 8'h10);
    act <= 1'h1; // Bus echoes the forced K back to the pin
    repeat (2) @(posedge ref_clk);
    #1 chk(12'({oe, dp, dm, fw}), 12'hC);
    wr(A1, 8'h00);
    @(posedge ref_clk);
    act <= 1'h0; // Echo ends with the drive
    repeat (4) @(posedge ref_clk);
    #1 chk(12'({oe, fw}), 12'h0);
    @(posedge ref_clk);
    act <= 1'h1;
    repeat (4) @(posedge ref_clk);
    act <= 1'h0;
    #1 chk(12'({oe, fw}), 12'h1);
    repeat (4) @(posedge ref_clk);
    cl(3);
    susp <= 1'h0;
    #1 chk(12'(fw), 12'h0);
    $display("wake done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Reset for 5 cycles, then the scenarios
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_regs;
    t_ep0;
    t_ep12;
    t_wake;
    tally_and_finish;
  end
  // Watchdog, well beyond the roughly 130 cycles needed
  initial
  begin
    #40000;
    errors++;
    tally_and_finish;
  end
endmodule
